// ==== common/eeprom_slave_consts.vh ====
// Constants for the two-wire EEPROM slave pin logic
// Overview of operation
// - Serial clock edges sample incoming data and time outgoing data bits.
// - Data line is open drain: only pulled low or released.
// - Three strap inputs are compared with select code bits b3, b2, b1.
// - An unconnected strap input reads as logic 0.
// - Write-protect high refuses every write to the whole array.
// - Write-protect low or unconnected allows writes.
// - Under write protection select and address bytes ack, data bytes do not.
// - Storage is 128 pages of 32 bytes with error correction.
// - Single bytes change without rewriting their neighbours.
// - Extra 32-byte identification page, writable until locked; reset clears the lock.
// - Bus clock up to 1 MHz works; master must not go faster.
// - Start is data falling with clock high; stop is data rising.
// - Stop after a write command launches the programming cycle.
// - Only type codes 1010b (array) and 1011b (id page) are answered.
// - Transmitter releases after eight bits; receiver acks on ninth pulse.
`ifndef EEPROM_SLAVE_CONSTS_VH
`define EEPROM_SLAVE_CONSTS_VH

`define TYPE_ARRAY 4'h0a
`define TYPE_IDPAGE 4'h0b
`define PAGE_COUNT 128
`define PAGE_BYTES 32
`define ADDR_BITS 12
`define LOCK_ADDR_BIT 10
`define CODE_BITS 12
`define CLK_MHZ 20
`define WR_TIME_US 4000
`define WR_CYCLES (`WR_TIME_US * `CLK_MHZ)
`define FILT_CYCLES 2
`define ID_FILL 8'h00

`endif

// ==== src/eeprom_i2c_slave_pin_logic.v ====
// Two-wire EEPROM slave: pin front end, byte engine, page buffer and storage
`timescale 1ns/1ps
`include "eeprom_slave_consts.vh"

module eeprom_i2c_slave_pin_logic #(
    parameter WR_CYCLES = `WR_CYCLES,
    parameter FILT_CYCLES = `FILT_CYCLES
) (
    // Clock and reset
    input wire I_CLK,
    input wire I_RST,
    // Bus pins
    input wire I_SCL,
    input wire I_SDA,
    output wire O_SDA,
    output reg O_SDA_OE,
    // Straps
    input wire I_SELECT_STRAP_BIT2,
    input wire I_SELECT_STRAP_BIT1,
    input wire I_SELECT_STRAP_BIT0,
    input wire I_WRITE_PROTECT_IN,
    // Status
    output reg O_BUSY,
    output reg O_LOCKED,
    output reg O_ECC_CORRECTED
);
    localparam S_IDLE = 3'h0;
    localparam S_DEV = 3'h1;
    localparam S_ADDRH = 3'h2;
    localparam S_ADDRL = 3'h3;
    localparam S_WDATA = 3'h4;
    localparam S_RDATA = 3'h5;
    localparam S_WAIT = 3'h6;

    // Hamming(12,8): parity at codeword positions 1,2,4,8
    function [11:0] ecc_enc;
        input [7:0] d;
        reg p1, p2, p4, p8;
        begin
            p1 = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
            p2 = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
            p4 = d[1] ^ d[2] ^ d[3] ^ d[7];
            p8 = d[4] ^ d[5] ^ d[6] ^ d[7];
            ecc_enc = {d[7:4], p8, d[3:1], p4, d[0], p2, p1};
        end
    endfunction

    function [8:0] ecc_dec;
        input [11:0] c;
        reg [3:0] syn;
        reg [11:0] f;
        begin
            syn[0] = c[0] ^ c[2] ^ c[4] ^ c[6] ^ c[8] ^ c[10];
            syn[1] = c[1] ^ c[2] ^ c[5] ^ c[6] ^ c[9] ^ c[10];
            syn[2] = c[3] ^ c[4] ^ c[5] ^ c[6] ^ c[11];
            syn[3] = c[7] ^ c[8] ^ c[9] ^ c[10] ^ c[11];
            f = c;
            if (syn != 4'h0 && syn <= 4'hc)
            begin
                f[syn - 4'h1] = ~c[syn - 4'h1];
            end
            ecc_dec = {(syn != 4'h0), f[11:8], f[6:4], f[2]};
        end
    endfunction

    // Storage; the array has no reset, like real nonvolatile cells
    reg [11:0] mem [0:`PAGE_COUNT*`PAGE_BYTES-1];
    reg [11:0] idmem [0:`PAGE_BYTES-1];
    reg [7:0] pbuf [0:`PAGE_BYTES-1];
    reg [`PAGE_BYTES-1:0] pmask_r;

    // Synchronisers and deglitch filters
    reg scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;
    reg [2:0] strap_s1_r, strap_s2_r;
    reg wp_s1_r, wp_s2_r;
    reg scl_f_r, sda_f_r, scl_d_r, sda_d_r;
    reg [3:0] scl_cnt_r, sda_cnt_r;

    always @(posedge I_CLK)
    begin
        scl_s1_r <= I_SCL;
        scl_s2_r <= scl_s1_r;
        sda_s1_r <= I_SDA;
        sda_s2_r <= sda_s1_r;
        strap_s1_r <= {I_SELECT_STRAP_BIT2, I_SELECT_STRAP_BIT1, I_SELECT_STRAP_BIT0};
        strap_s2_r <= strap_s1_r;
        wp_s1_r <= I_WRITE_PROTECT_IN;
        wp_s2_r <= wp_s1_r;
    end

    // A level must persist FILT_CYCLES samples before it is believed
    always @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            scl_cnt_r <= 4'h0;
            sda_cnt_r <= 4'h0;
        end
        else
        begin
            scl_d_r <= scl_f_r;
            sda_d_r <= sda_f_r;
            if (scl_s2_r == scl_f_r)
                scl_cnt_r <= 4'h0;
            else if (scl_cnt_r == FILT_CYCLES[3:0] - 4'h1)
            begin
                scl_f_r <= scl_s2_r;
                scl_cnt_r <= 4'h0;
            end
            else
                scl_cnt_r <= scl_cnt_r + 4'h1;
            if (sda_s2_r == sda_f_r)
                sda_cnt_r <= 4'h0;
            else if (sda_cnt_r == FILT_CYCLES[3:0] - 4'h1)
            begin
                sda_f_r <= sda_s2_r;
                sda_cnt_r <= 4'h0;
            end
            else
                sda_cnt_r <= sda_cnt_r + 4'h1;
        end
    end

    wire scl_rise = scl_f_r & ~scl_d_r;
    wire scl_fall = ~scl_f_r & scl_d_r;
    wire start_det = scl_f_r & scl_d_r & ~sda_f_r & sda_d_r;
    wire stop_det = scl_f_r & scl_d_r & sda_f_r & ~sda_d_r;

    // Byte engine
    reg [2:0] state_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg [7:0] tx_r;
    reg [`ADDR_BITS-1:0] addr_r;
    reg idsel_r, ack_ok_r, lock_cmd_r;
    reg [31:0] busy_cnt_r;
    reg [5:0] commit_r;

    wire [8:0] rd_word = idsel_r ? ecc_dec(idmem[addr_r[4:0]]) : ecc_dec(mem[addr_r]);
    wire type_ok = (shift_r[7:4] == `TYPE_ARRAY) || (shift_r[7:4] == `TYPE_IDPAGE);
    wire sel_ok = type_ok && (shift_r[3:1] == strap_s2_r);
    wire data_blocked = wp_s2_r || (idsel_r && O_LOCKED);

    assign O_SDA = 1'b0;

    always @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            state_r <= S_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            addr_r <= {`ADDR_BITS{1'b0}};
            idsel_r <= 1'b0;
            ack_ok_r <= 1'b0;
            lock_cmd_r <= 1'b0;
            pmask_r <= {`PAGE_BYTES{1'b0}};
            O_SDA_OE <= 1'b0;
            O_BUSY <= 1'b0;
            O_LOCKED <= 1'b0;
            O_ECC_CORRECTED <= 1'b0;
            busy_cnt_r <= 32'h0000_0000;
            commit_r <= 6'h00;
        end
        else if (O_BUSY)
        begin
            // Bus is ignored while programming; a start here is simply missed
            O_SDA_OE <= 1'b0;
            state_r <= S_IDLE;
            if (commit_r < `PAGE_BYTES)
            begin
                if (pmask_r[commit_r[4:0]])
                begin
                    if (lock_cmd_r)
                        O_LOCKED <= 1'b1;
                    else if (idsel_r)
                        idmem[commit_r[4:0]] <= ecc_enc(pbuf[commit_r[4:0]]);
                    else
                        mem[{addr_r[11:5], commit_r[4:0]}] <= ecc_enc(pbuf[commit_r[4:0]]);
                end
                commit_r <= commit_r + 6'h01;
            end
            if (busy_cnt_r >= WR_CYCLES - 1)
            begin
                O_BUSY <= 1'b0;
                pmask_r <= {`PAGE_BYTES{1'b0}};
            end
            busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
        end
        else if (stop_det)
        begin
            O_SDA_OE <= 1'b0;
            state_r <= S_IDLE;
            if (pmask_r != {`PAGE_BYTES{1'b0}})
            begin
                O_BUSY <= 1'b1;
                busy_cnt_r <= 32'h0000_0000;
                commit_r <= 6'h00;
            end
        end
        else if (start_det)
        begin
            O_SDA_OE <= 1'b0;
            state_r <= S_DEV;
            bit_cnt_r <= 4'h0;
            pmask_r <= {`PAGE_BYTES{1'b0}};
        end
        else if (state_r != S_IDLE && state_r != S_WAIT)
        begin
            if (scl_rise)
            begin
                if (bit_cnt_r < 4'h8)
                    shift_r <= {shift_r[6:0], sda_f_r};
                if (bit_cnt_r == 4'h8 && state_r == S_RDATA)
                    ack_ok_r <= ~sda_f_r;
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            else if (scl_fall)
            begin
                if (bit_cnt_r == 4'h8)
                begin
                    O_SDA_OE <= 1'b0;
                    ack_ok_r <= 1'b0;
                    case (state_r)
                        S_DEV:
                        begin
                            if (sel_ok)
                            begin
                                O_SDA_OE <= 1'b1;
                                ack_ok_r <= 1'b1;
                                idsel_r <= shift_r[4];
                            end
                        end
                        S_ADDRH:
                        begin
                            O_SDA_OE <= 1'b1;
                            ack_ok_r <= 1'b1;
                            addr_r[11:8] <= shift_r[3:0];
                            lock_cmd_r <= idsel_r & shift_r[`LOCK_ADDR_BIT - 8];
                        end
                        S_ADDRL:
                        begin
                            O_SDA_OE <= 1'b1;
                            ack_ok_r <= 1'b1;
                            addr_r[7:0] <= shift_r;
                        end
                        S_WDATA:
                        begin
                            if (!data_blocked)
                            begin
                                O_SDA_OE <= 1'b1;
                                ack_ok_r <= 1'b1;
                                pbuf[addr_r[4:0]] <= shift_r;
                                pmask_r[addr_r[4:0]] <= 1'b1;
                                addr_r[4:0] <= addr_r[4:0] + 5'h01;
                            end
                        end
                        default:
                        begin
                            ack_ok_r <= 1'b0;
                        end
                    endcase
                end
                else if (bit_cnt_r == 4'h9)
                begin
                    O_SDA_OE <= 1'b0;
                    bit_cnt_r <= 4'h0;
                    if (!ack_ok_r)
                        state_r <= S_WAIT;
                    else
                    begin
                        case (state_r)
                            S_DEV:
                                state_r <= shift_r[0] ? S_RDATA : S_ADDRH;
                            S_ADDRH:
                                state_r <= S_ADDRL;
                            S_ADDRL:
                                state_r <= S_WDATA;
                            default:
                                state_r <= state_r;
                        endcase
                        if (state_r == S_RDATA || (state_r == S_DEV && shift_r[0]))
                        begin
                            // Data leaves the flop set on the clock low phase
                            tx_r <= rd_word[7:0];
                            O_ECC_CORRECTED <= rd_word[8];
                            O_SDA_OE <= ~rd_word[7];
                            // Pointer steps past every byte it loads, so a sequential read moves on
                            addr_r <= addr_r + {{(`ADDR_BITS-1){1'b0}}, 1'b1};
                        end
                    end
                end
                else if (state_r == S_RDATA)
                begin
                    O_SDA_OE <= ~tx_r[7 - bit_cnt_r[2:0]];
                    if (bit_cnt_r == 4'h8)
                        O_SDA_OE <= 1'b0;
                end
            end
        end
    end
endmodule

// ==== test/eeprom_pin_monitor.sv ====
// Checker for the EEPROM slave pin logic
`timescale 1ns/1ps
module eeprom_pin_monitor #(parameter WR_CYCLES = 400) (
    // Clock and reset
    input wire I_CLK,
    input wire I_RST,
    // Bus
    input wire I_SCL,
    input wire I_SDA,
    input wire O_SDA,
    input wire O_SDA_OE,
    // Straps
    input wire I_SELECT_STRAP_BIT2,
    input wire I_SELECT_STRAP_BIT1,
    input wire I_SELECT_STRAP_BIT0,
    input wire I_WRITE_PROTECT_IN,
    // Status
    input wire O_BUSY,
    input wire O_LOCKED,
    input wire O_ECC_CORRECTED
);
    reg [3:0] bit_r;
    reg [3:0] byte_r;
    reg [7:0] sh_r;
    reg rw_r;
    reg [5:0] stop_age_r;
    reg [15:0] busy_cnt_r;
    // Decode straight from the pins; sound only while data moves with the clock low
    always @(posedge I_CLK)
    begin
        if (I_RST || (I_SCL && $fell(I_SDA)))
        begin
            bit_r <= 4'h0;
            byte_r <= 4'h0;
        end
        else if ($rose(I_SCL))
        begin
            sh_r <= {sh_r[6:0], I_SDA};
            bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
            if (bit_r == 4'h8 && byte_r != 4'hf)
                byte_r <= byte_r + 4'h1;
            if (bit_r == 4'h7 && byte_r == 4'h0)
                rw_r <= I_SDA;
        end
        stop_age_r <= (I_SCL && $rose(I_SDA)) ? 6'h00 : stop_age_r + {5'h00, stop_age_r != 6'h3f};
        busy_cnt_r <= O_BUSY ? busy_cnt_r + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    sequence ack_slot;
        $rose(I_SCL) && bit_r == 4'h8;
    endsequence
    sequence oe_gone;
        ##[1:24] !O_SDA_OE;
    endsequence
    sda_low_only_a: assert property (O_SDA == 1'b0)
        else $error("data pin value not low");
    oe_scl_low_a: assert property ($changed(O_SDA_OE) |-> !I_SCL)
        else $error("data drive moved with clock high");
    sel_ack_a: assert property ((ack_slot ##0 byte_r == 4'h0) |-> O_SDA_OE == (sh_r[7:5] == 3'b101 &&
        sh_r[3:1] == {I_SELECT_STRAP_BIT2, I_SELECT_STRAP_BIT1, I_SELECT_STRAP_BIT0} && !O_BUSY)) else $error("select ack wrong");
    wp_nack_a: assert property ((ack_slot ##0 (byte_r >= 4'h3 && !rw_r && I_WRITE_PROTECT_IN)) |-> !O_SDA_OE)
        else $error("data byte acked under protection");
    ack_release_a: assert property ((ack_slot ##0 (O_SDA_OE && !rw_r)) |-> oe_gone)
        else $error("ack not released");
    busy_after_stop_a: assert property ($rose(O_BUSY) |-> stop_age_r <= 6'h0c)
        else $error("busy without stop");
    busy_len_a: assert property ($fell(O_BUSY) |-> busy_cnt_r >= WR_CYCLES - 1 && busy_cnt_r <= WR_CYCLES + 1)
        else $error("busy length wrong");
    busy_quiet_a: assert property (O_BUSY |-> !O_SDA_OE)
        else $error("drive during busy");
    lock_hold_a: assert property (O_LOCKED |=> O_LOCKED)
        else $error("lock cleared");
endmodule
bind eeprom_i2c_slave_pin_logic eeprom_pin_monitor #(.WR_CYCLES(WR_CYCLES)) mon (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE), .I_SELECT_STRAP_BIT2(I_SELECT_STRAP_BIT2),
    .I_SELECT_STRAP_BIT1(I_SELECT_STRAP_BIT1), .I_SELECT_STRAP_BIT0(I_SELECT_STRAP_BIT0),
    .I_WRITE_PROTECT_IN(I_WRITE_PROTECT_IN), .O_BUSY(O_BUSY), .O_LOCKED(O_LOCKED), .O_ECC_CORRECTED(O_ECC_CORRECTED));

// ==== test/i2c_master_model.sv ====
// Behavioural two-wire bus master
`timescale 1ns/1ps
module i2c_master_model (
    // Bus
    output logic scl,
    output logic sda_oe,
    input wire logic sda
);
    logic s;
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // Low 600 ns, high 400 ns: stays at 1 MHz and leaves the slave's synchroniser time
    task automatic bit_cyc(input logic b, output logic r);
        #300 sda_oe = !b;
        #300 scl = 1'b1;
        #350 r = sda;
        #50 scl = 1'b0;
    endtask
    task automatic start_c;
        #300 sda_oe = 1'b0;
        #300 scl = 1'b1;
        #400 sda_oe = 1'b1;
        #400 scl = 1'b0;
    endtask
    task automatic stop_c;
        #300 sda_oe = 1'b1;
        #300 scl = 1'b1;
        #400 sda_oe = 1'b0;
        #400;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
        bit_cyc(1'b1, s);
        ack = !s;
    endtask
    task automatic recv(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
        bit_cyc(!ack, s);
    endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the EEPROM slave pin logic
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] strap = 3'h0;
    logic wp = 1'b0;
    logic [7:0] d0;
    logic [7:0] d1;
    logic ack;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    wire scl, m_oe, o_sda, oe, busy, locked, ecc;
    // Pull-up on the data wire; either party can only pull it low
    wire sda_w = (oe ? o_sda : 1'b1) & !m_oe;
    always #25 clk = ~clk;
    eeprom_i2c_slave_pin_logic #(.WR_CYCLES(400)) dut (.I_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda_w),
        .O_SDA(o_sda), .O_SDA_OE(oe), .I_SELECT_STRAP_BIT2(strap[2]), .I_SELECT_STRAP_BIT1(strap[1]),
        .I_SELECT_STRAP_BIT0(strap[0]), .I_WRITE_PROTECT_IN(wp), .O_BUSY(busy), .O_LOCKED(locked),
        .O_ECC_CORRECTED(ecc));
    i2c_master_model mst (.scl(scl), .sda_oe(m_oe), .sda(sda_w));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tx(input logic [7:0] b, input logic exp);
        mst.send(b, ack);
        check("ack", ack, exp);
    endtask
    task automatic wr(input logic [7:0] sel, input logic [15:0] a, input logic [7:0] d, input logic ex);
        mst.start_c();
        tx(sel, 1'b1);
        tx(a[15:8], 1'b1);
        tx(a[7:0], 1'b1);
        tx(d, ex);
        mst.stop_c();
        repeat (12) @(negedge clk);
        check("busy", busy, ex);
    endtask
    task automatic rd(input logic [7:0] sel, input logic [15:0] a);
        mst.start_c();
        tx(sel, 1'b1);
        tx(a[15:8], 1'b1);
        tx(a[7:0], 1'b1);
        mst.start_c();
        tx(sel | 8'h01, 1'b1);
        mst.recv(1'b1, d0);
        mst.recv(1'b0, d1);
        mst.stop_c();
    endtask
    task automatic idle;
        for (int i = 0; i < 1000 && busy === 1'b1; i++) @(negedge clk);
        check("idle", busy, 1'b0);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        check("reset", {oe, busy, locked, ecc}, 8'h00);
        for (int t = 0; t < 16; t++)
        begin
            mst.start_c();
            tx({t[3:0], 4'h0}, t == 10 || t == 11);
            mst.stop_c();
        end
        @(negedge clk) strap = 3'h5;
        mst.start_c();
        tx(8'haa, 1'b1);
        mst.stop_c();
        mst.start_c();
        tx(8'ha4, 1'b0);
        mst.stop_c();
        @(negedge clk) strap = 3'h0;
        wr(8'ha0, 16'h0123, 8'h5a, 1'b1);
        mst.start_c();
        tx(8'ha0, 1'b0);
        mst.stop_c();
        idle();
        wr(8'ha0, 16'h0124, 8'hc3, 1'b1);
        idle();
        @(negedge clk) wp = 1'b1;
        wr(8'ha0, 16'h0123, 8'h00, 1'b0);
        @(negedge clk) wp = 1'b0;
        rd(8'ha0, 16'h0123);
        check("byte", d0, 8'h5a);
        check("next", d1, 8'hc3);
        check("ecc", ecc, 1'b0);
        wr(8'hb0, 16'h0000, 8'h77, 1'b1);
        idle();
        check("unlocked", locked, 1'b0);
        wr(8'hb0, 16'h0400, 8'h77, 1'b1);
        idle();
        check("locked", locked, 1'b1);
        wr(8'hb0, 16'h0000, 8'h12, 1'b0);
        rd(8'hb0, 16'h0000);
        check("id", d0, 8'h77);
        stop_test();
    end
endmodule
